// [dv/crf_dma_model.sv]
`timescale 1ns/1ns
// Stand-in for the DMA unit: copies for a fixed time, then acknowledges
module crf_dma_model #(
    parameter int COPY_CYCLES = 40
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic dma_req,
    output logic dma_ack
);
    int unsigned cnt; // Copy time elapsed since the request rose
    // Ack is a one-cycle pulse; a slow copy keeps the request up for a while
    always_ff @(posedge mclk) begin
        if (!rst_n || !dma_req) begin
            cnt <= 0;
            dma_ack <= 1'b0;
        end else if (cnt == COPY_CYCLES) begin
            dma_ack <= 1'b1;
            cnt <= cnt + 1;
        end else begin
            dma_ack <= 1'b0;
            cnt <= (cnt > COPY_CYCLES) ? cnt : cnt + 1;
        end
    end
endmodule : crf_dma_model

// [dv/test_crf_rx_store.sv]
`timescale 1ns/1ns
`include "crf_map.svh"
module test_crf_rx_store
    import crf_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic id_valid = 1'b0;
    logic [28:0] rx_id = 29'h0;
    logic [28:0] masked_id;
    logic rx_valid = 1'b0;
    crf_req_s rx_req = '0;
    crf_store_s store;
    logic filter_skip;
    logic dma_req;
    logic dma_ack;
    logic [31:0] rd; // Data of the last read
    logic rd_err; // Error answer of the last transfer
    int fail_count = 0;
    int samples_checked = 0;
    crf_rx_store crf_rx_store_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .id_valid(id_valid), .rx_id(rx_id), .masked_id(masked_id),
        .rx_valid(rx_valid), .rx_req(rx_req), .store(store), .filter_skip(filter_skip),
        .dma_req(dma_req), .dma_ack(dma_ack));
    crf_dma_model crf_dma_model_inst (.mclk(mclk), .rst_n(rst_n), .dma_req(dma_req),
        .dma_ack(dma_ack));
    // 50 MHz clock
    initial forever #10 mclk = ~mclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check(rd, exp);
    endtask : rdchk
    // One accepted message; the store answer is looked at one cycle later
    task automatic send(input logic err, input logic [2:0] code, input logic [10:0] sid);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_req <= '{err: err, ext_filter_config_code: code, ext_filter_second_id: sid};
        @(posedge mclk);
        rx_valid <= 1'b0;
        #1;
    endtask : send
    task automatic stchk(input logic [1:0] kind, input logic [15:0] addr);
        check({13'h0, store}, {13'h0, 1'b1, kind, addr});
    endtask : stchk
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        // Reset values and an unmapped address
        rdchk(`CRF_A_XMASK, 32'h1FFFFFFF);
        rdchk(`CRF_A_F0CFG, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        check({31'h0, rd_err}, 32'h1);
        check(rd, 32'h0);
        // Identifier masking
        apb(1'b1, `CRF_A_XMASK, 32'h0F0F0F0F);
        @(posedge mclk);
        id_valid <= 1'b1;
        rx_id <= 29'h1FFFFFFF;
        @(posedge mclk);
        id_valid <= 1'b0;
        #1;
        check({3'h0, masked_id}, 32'h0F0F0F0F);
        $display("test mask done");
        // FIFO 0: depth 2, watermark 1, blocking, 5-word elements from 0x100
        apb(1'b1, `CRF_A_ESZ, 32'h001);
        apb(1'b1, `CRF_A_F0CFG, 32'h01000102);
        send(1'b0, 3'h1, 11'h0);
        stchk(2'd0, 16'h0100);
        send(1'b0, 3'h1, 11'h0);
        stchk(2'd0, 16'h0105);
        rdchk(`CRF_A_F0STAT, 32'h01020000);
        send(1'b0, 3'h1, 11'h0);
        check({31'h0, store.valid}, 32'h0);
        rdchk(`CRF_A_F0STAT, 32'h03020000);
        rdchk(`CRF_A_IRQ, 32'h07);
        apb(1'b1, `CRF_A_F0ACK, 32'h1);
        rdchk(`CRF_A_F0STAT, 32'h00010001);
        send(1'b0, 3'h1, 11'h0);
        stchk(2'd0, 16'h0100);
        // Full FIFO 0 switched to overwrite: the element at put index 1 is reused
        apb(1'b1, `CRF_A_F0CFG, 32'h01008102);
        send(1'b0, 3'h1, 11'h0);
        stchk(2'd0, 16'h0105);
        $display("test fifo0 done");
        // FIFO 1: overwrite mode, 4-word elements from 0x300, errored frame first
        apb(1'b1, `CRF_A_F1CFG, 32'h03008002);
        send(1'b1, 3'h2, 11'h0);
        stchk(2'd1, 16'h0300);
        rdchk(`CRF_A_F1STAT, 32'h0);
        send(1'b0, 3'h2, 11'h0);
        stchk(2'd1, 16'h0300);
        send(1'b0, 3'h2, 11'h0);
        stchk(2'd1, 16'h0304);
        send(1'b0, 3'h2, 11'h0);
        stchk(2'd1, 16'h0300);
        rdchk(`CRF_A_F1STAT, 32'h01020101);
        apb(1'b1, `CRF_A_IRQ, 32'h7F);
        $display("test fifo1 done");
        // Dedicated buffer 3 from 0x200, locking and write-one clearing
        apb(1'b1, `CRF_A_BUFCFG, 32'h0200);
        send(1'b0, 3'h7, 11'h003);
        stchk(2'd2, 16'h020C);
        rdchk(`CRF_A_IRQ, 32'h40);
        rdchk(`CRF_A_NDLO, 32'h8);
        send(1'b0, 3'h7, 11'h003);
        check({30'h0, filter_skip, store.valid}, 32'h2);
        apb(1'b1, `CRF_A_NDLO, 32'h0);
        rdchk(`CRF_A_NDLO, 32'h8);
        apb(1'b1, `CRF_A_NDLO, 32'h8);
        rdchk(`CRF_A_NDLO, 32'h0);
        apb(1'b1, `CRF_A_IRQ, 32'h40);
        $display("test buffer done");
        // Debug capture: out of order first, then A, B, C into buffers 61..63
        send(1'b0, 3'h7, 11'h43E);
        send(1'b0, 3'h7, 11'h63F);
        @(posedge mclk);
        #1;
        check({31'h0, dma_req}, 32'h0);
        send(1'b0, 3'h7, 11'h23D);
        stchk(2'd3, 16'h02F4);
        send(1'b0, 3'h7, 11'h43E);
        stchk(2'd3, 16'h02F8);
        send(1'b0, 3'h7, 11'h63F);
        stchk(2'd3, 16'h02FC);
        @(posedge mclk);
        #1;
        check({31'h0, dma_req}, 32'h1);
        apb(1'b0, `CRF_A_F1STAT, 32'h0);
        check({30'h0, rd[31:30]}, 32'h3);
        rdchk(`CRF_A_IRQ, 32'h0);
        rdchk(`CRF_A_NDHI, 32'h0);
        send(1'b0, 3'h7, 11'h23D);
        check({31'h0, store.valid}, 32'h0);
        for (int i = 0; i < 60 && dma_req === 1'b1; i++) @(posedge mclk);
        #1;
        check({31'h0, dma_req}, 32'h0);
        apb(1'b0, `CRF_A_F1STAT, 32'h0);
        check({30'h0, rd[31:30]}, 32'h0);
        $display("test debug done");
        print_verdict();
    end
endmodule : test_crf_rx_store

// [rtl/crf_map.svh]
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
// Register byte offsets
`define CRF_A_XMASK 8'h00
`define CRF_A_F0CFG 8'h04
`define CRF_A_F1CFG 8'h08
`define CRF_A_F0STAT 8'h0C
`define CRF_A_F1STAT 8'h10
`define CRF_A_F0ACK 8'h14
`define CRF_A_F1ACK 8'h18
`define CRF_A_BUFCFG 8'h1C
`define CRF_A_ESZ 8'h20
`define CRF_A_IRQ 8'h24
`define CRF_A_NDLO 8'h28
`define CRF_A_NDHI 8'h2C
// Reset values, write masks and depth limit
`define CRF_XMASK_RST 29'h1FFFFFFF
`define CRF_CFG_WMASK 32'hFFFFFF7F
`define CRF_ESZ_WMASK 12'h777
`define CRF_DEPTH_MAX 7'h40
// FIFO config fields: size, watermark, mode, start word address
`define CRF_CFG_SIZE 6:0
`define CRF_CFG_WM 14:8
`define CRF_CFG_OM 15
`define CRF_CFG_SA 31:16
// Element-size code fields per store target
`define CRF_ESZ_F0 2:0
`define CRF_ESZ_F1 6:4
`define CRF_ESZ_BUF 10:8
// Words per element for codes 0..7, code 0 in the low bits
`define CRF_ESZ_TBL {5'h12, 5'h0E, 5'h0A, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04}
// Filter element action codes and debug message codes
`define CRF_FEC_FIFO0 3'h1
`define CRF_FEC_FIFO1 3'h2
`define CRF_FEC_BUF 3'h7
`define CRF_DBG_A 2'h1
`define CRF_DBG_B 2'h2
`define CRF_DBG_C 2'h3
// Flag bit positions
`define CRF_IRQ_WM0 0
`define CRF_IRQ_FULL0 1
`define CRF_IRQ_LOST0 2
`define CRF_IRQ_WM1 3
`define CRF_IRQ_FULL1 4
`define CRF_IRQ_LOST1 5
`define CRF_IRQ_DRX 6
`endif

// [rtl/crf_pkg.sv]
package crf_pkg;
`include "crf_map.svh"
    // One accepted message as handed over by the filter stage
    typedef struct packed {
        logic err;                 // Protocol error seen during reception
        logic [2:0] ext_filter_config_code;
        logic [10:0] ext_filter_second_id;
    } crf_req_s;
    // Store command towards the message memory writer
    typedef struct packed {
        logic valid;
        logic [1:0] kind;          // 0 fifo0, 1 fifo1, 2 buffer, 3 debug
        logic [15:0] addr;         // Word address of the element
    } crf_store_s;
    // Per-FIFO index state
    typedef struct packed {
        logic [5:0] fifo_get_index;
        logic [5:0] fifo_put_index;
        logic fifo_full_status;
        logic fifo_message_lost;
    } crf_fifo_s;
    // Debug capture progress
    typedef enum logic [1:0] {DBG_IDLE, DBG_GOT_A, DBG_GOT_AB, DBG_REQ} crf_dbg_e;
endpackage : crf_pkg

// [rtl/crf_rx_store.sv]
`timescale 1ns/1ns
module crf_rx_store
    import crf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic id_valid,
    input wire logic [28:0] rx_id,
    output logic [28:0] masked_id,
    input wire logic rx_valid,
    input wire crf_req_s rx_req,
    output crf_store_s store,
    output logic filter_skip,
    output logic dma_req,
    input wire logic dma_ack
);
    // Software-visible configuration
    logic [28:0] extended_id_and_mask, next_extended_id_and_mask;
    logic [31:0] cfg [2];             // rx_fifo0_config, rx_fifo1_config
    logic [31:0] next_cfg [2];
    logic [15:0] rx_buffer_start_address, next_rx_buffer_start_address;
    logic [11:0] esz, next_esz;       // Element size codes
    // Hardware state
    crf_fifo_s fs [2];
    crf_fifo_s next_fs [2];
    logic [6:0] irq, next_irq;        // Sticky event flags, write one to clear
    logic [63:0] ndat, next_ndat;     // New-data flags of dedicated buffers
    crf_dbg_e dbg, next_dbg;
    // Registered outputs
    logic [28:0] next_masked_id;
    crf_store_s next_store;
    logic next_filter_skip, next_dma_req;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    // Derived per-FIFO values
    logic [6:0] dep [2];
    logic [6:0] fill [2];
    logic [4:0] fwords [2];
    logic [4:0] bwords;
    logic wr, mapped;

    // Words per element for a size code
    function automatic logic [4:0] words_of(input logic [2:0] code);
        logic [39:0] tbl;
        tbl = `CRF_ESZ_TBL;
        return tbl[5*code +: 5];
    endfunction : words_of

    // Wrapping increment within the configured depth
    function automatic logic [5:0] inc_of(input logic [5:0] x, input logic [6:0] d);
        return ({1'b0, x} + 7'h01 >= d) ? 6'h00 : x + 6'h01;
    endfunction : inc_of

    // Fill level; a full FIFO reports its depth
    function automatic logic [6:0] fill_of(input crf_fifo_s f, input logic [6:0] d);
        logic [6:0] p, g;
        p = {1'b0, f.fifo_put_index};
        g = {1'b0, f.fifo_get_index};
        if (f.fifo_full_status) begin
            return d;
        end
        return (p >= g) ? p - g : p + d - g;
    endfunction : fill_of

    // Depth, fill and element size of both FIFOs
    for (genvar i = 0; i < 2; i++) begin : g_fifo
        // Sizes above the maximum are clamped so indices never overrun
        assign dep[i] = (cfg[i][`CRF_CFG_SIZE] > `CRF_DEPTH_MAX) ? `CRF_DEPTH_MAX
                        : cfg[i][`CRF_CFG_SIZE];
        assign fill[i] = fill_of(fs[i], dep[i]);
        assign fwords[i] = words_of(i == 0 ? esz[`CRF_ESZ_F0] : esz[`CRF_ESZ_F1]);
    end
    assign bwords = words_of(esz[`CRF_ESZ_BUF]);
    assign wr = psel & penable & pready & pwrite;

    // Next state of registers, FIFOs, buffers and debug capture
    always_comb begin : p_next
        logic [5:0] bi, ack;
        logic [6:0] nf;
        logic hit, k;
        bi = rx_req.ext_filter_second_id[5:0];
        ack = pwdata[5:0];
        nf = 7'h00;
        hit = 1'b0;
        k = 1'b0;
        next_extended_id_and_mask = extended_id_and_mask;
        next_cfg = cfg;
        next_rx_buffer_start_address = rx_buffer_start_address;
        next_esz = esz;
        next_fs = fs;
        next_irq = irq;
        next_ndat = ndat;
        next_dbg = dbg;
        next_masked_id = masked_id;
        next_store = '0;
        next_filter_skip = 1'b0;
        // Mask before the extended filter list sees the identifier
        if (id_valid) begin
            next_masked_id = rx_id & extended_id_and_mask;
        end
        // Software writes go first so that a same-cycle hardware set wins
        if (wr) begin
            case (paddr)
                `CRF_A_XMASK: next_extended_id_and_mask = pwdata[28:0];
                `CRF_A_F0CFG: next_cfg[0] = pwdata & `CRF_CFG_WMASK;
                `CRF_A_F1CFG: next_cfg[1] = pwdata & `CRF_CFG_WMASK;
                `CRF_A_F0ACK, `CRF_A_F1ACK: begin
                    k = (paddr == `CRF_A_F1ACK);
                    // Out-of-range acknowledge is ignored
                    if ({1'b0, ack} < dep[k]) begin
                        next_fs[k].fifo_get_index = ack;
                        next_fs[k].fifo_message_lost = 1'b0;
                        if (fs[k].fifo_put_index != ack) begin
                            next_fs[k].fifo_full_status = 1'b0;
                        end
                    end
                end
                `CRF_A_BUFCFG: next_rx_buffer_start_address = pwdata[15:0];
                `CRF_A_ESZ: next_esz = pwdata[11:0] & `CRF_ESZ_WMASK;
                `CRF_A_IRQ: next_irq = irq & ~pwdata[6:0];
                `CRF_A_NDLO: next_ndat[31:0] = ndat[31:0] & ~pwdata;
                `CRF_A_NDHI: next_ndat[63:32] = ndat[63:32] & ~pwdata;
                default: ;
            endcase
        end
        // DMA acknowledge ends the frozen window and re-arms capture
        if (dbg == DBG_REQ && dma_ack) begin
            next_dbg = DBG_IDLE;
        end
        if (rx_valid) begin
            if (rx_req.ext_filter_config_code == `CRF_FEC_BUF
                    && rx_req.ext_filter_second_id[10:9] == 2'h0) begin
                if (ndat[bi]) begin
                    // Locked buffer: the filter stage moves on to the next element
                    next_filter_skip = 1'b1;
                end else begin
                    next_store.valid = 1'b1;
                    next_store.kind = 2'h2;
                    next_store.addr = 16'(rx_buffer_start_address
                                      + 16'(bi) * 16'(bwords));
                    // Errored frame overwrites but is not flagged as new
                    if (!rx_req.err) begin
                        next_ndat[bi] = 1'b1;
                        next_irq[`CRF_IRQ_DRX] = 1'b1;
                    end
                end
            end else if (rx_req.ext_filter_config_code == `CRF_FEC_BUF) begin
                // Debug message; rejected while DMA owns the memory words
                if (dbg != DBG_REQ) begin
                    next_store.valid = 1'b1;
                    next_store.kind = 2'h3;
                    next_store.addr = 16'(rx_buffer_start_address
                                      + 16'(bi) * 16'(bwords));
                    // No new-data or buffer-stored flag for debug traffic
                    if (!rx_req.err) begin
                        case (rx_req.ext_filter_second_id[10:9])
                            `CRF_DBG_A: next_dbg = DBG_GOT_A;
                            `CRF_DBG_B: next_dbg = (dbg == DBG_GOT_A) ? DBG_GOT_AB
                                                   : DBG_IDLE;
                            `CRF_DBG_C: next_dbg = (dbg == DBG_GOT_AB) ? DBG_REQ
                                                   : DBG_IDLE;
                            default: next_dbg = dbg;
                        endcase
                    end
                end
            end else if (rx_req.ext_filter_config_code == `CRF_FEC_FIFO0
                    || rx_req.ext_filter_config_code == `CRF_FEC_FIFO1) begin
                k = (rx_req.ext_filter_config_code == `CRF_FEC_FIFO1);
                if (dep[k] != 7'h00) begin
                    if (fs[k].fifo_full_status && !cfg[k][`CRF_CFG_OM]) begin
                        // Blocking and full: drop the message
                        next_fs[k].fifo_message_lost = 1'b1;
                        next_irq[3 * k + 2] = 1'b1;
                    end else begin
                        hit = 1'b1;
                        next_store.valid = 1'b1;
                        next_store.kind = {1'b0, k};
                        next_store.addr = 16'(cfg[k][`CRF_CFG_SA] + 16'(fs[k].fifo_put_index)
                                          * 16'(fwords[k]));
                    end
                end
                // An errored frame may overwrite the element but never commits it
                if (hit && !rx_req.err) begin
                    if (fs[k].fifo_full_status) begin
                        // Overwrite mode: the oldest element is sacrificed
                        next_fs[k].fifo_get_index = inc_of(fs[k].fifo_get_index,
                                                           dep[k]);
                    end
                    next_fs[k].fifo_put_index = inc_of(fs[k].fifo_put_index, dep[k]);
                    if (next_fs[k].fifo_put_index == next_fs[k].fifo_get_index) begin
                        next_fs[k].fifo_full_status = 1'b1;
                        next_irq[3 * k + 1] = 1'b1;
                    end
                    nf = fill_of(next_fs[k], dep[k]);
                    if (cfg[k][`CRF_CFG_WM] != 7'h00 && nf == cfg[k][`CRF_CFG_WM]) begin
                        next_irq[3 * k] = 1'b1;
                    end
                end
            end
        end
        next_dma_req = (next_dbg == DBG_REQ);
    end

    // Status word of one FIFO; debug progress rides in FIFO 1's word
    function automatic logic [31:0] stat_of(input crf_fifo_s f, input logic [6:0] fl,
                                            input logic [1:0] d);
        return {d, 4'h0, f.fifo_message_lost, f.fifo_full_status, 1'b0, fl,
                2'h0, f.fifo_put_index, 2'h0, f.fifo_get_index};
    endfunction : stat_of

    // APB read data and answer; one wait state keeps prdata a flop
    always_comb begin : p_apb
        next_prdata = prdata;
        next_pready = psel & penable & ~pready;
        next_pslverr = 1'b0;
        mapped = 1'b1;
        if (psel & penable & ~pready) begin
            case (paddr)
                `CRF_A_XMASK: next_prdata = {3'h0, extended_id_and_mask};
                `CRF_A_F0CFG: next_prdata = cfg[0];
                `CRF_A_F1CFG: next_prdata = cfg[1];
                `CRF_A_F0STAT: next_prdata = stat_of(fs[0], fill[0], 2'h0);
                `CRF_A_F1STAT: next_prdata = stat_of(fs[1], fill[1], dbg);
                `CRF_A_F0ACK: next_prdata = {26'h0, fs[0].fifo_get_index};
                `CRF_A_F1ACK: next_prdata = {26'h0, fs[1].fifo_get_index};
                `CRF_A_BUFCFG: next_prdata = {16'h0, rx_buffer_start_address};
                `CRF_A_ESZ: next_prdata = {20'h0, esz};
                `CRF_A_IRQ: next_prdata = {25'h0, irq};
                `CRF_A_NDLO: next_prdata = ndat[31:0];
                `CRF_A_NDHI: next_prdata = ndat[63:32];
                default: begin
                    next_prdata = 32'h00000000;
                    mapped = 1'b0;
                end
            endcase
            next_pslverr = ~mapped;
        end
    end

    // All state registers; reset gives blocking mode and empty FIFOs
    always_ff @(posedge mclk) begin : p_regs
        if (!rst_n) begin
            extended_id_and_mask <= `CRF_XMASK_RST;
            cfg[0] <= 32'h00000000;
            cfg[1] <= 32'h00000000;
            rx_buffer_start_address <= 16'h0000;
            esz <= 12'h000;
            fs[0] <= '0;
            fs[1] <= '0;
            irq <= 7'h00;
            ndat <= 64'h0000000000000000;
            dbg <= DBG_IDLE;
            masked_id <= 29'h00000000;
            store <= '0;
            filter_skip <= 1'b0;
            dma_req <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            extended_id_and_mask <= next_extended_id_and_mask;
            cfg <= next_cfg;
            rx_buffer_start_address <= next_rx_buffer_start_address;
            esz <= next_esz;
            fs <= next_fs;
            irq <= next_irq;
            ndat <= next_ndat;
            dbg <= next_dbg;
            masked_id <= next_masked_id;
            store <= next_store;
            filter_skip <= next_filter_skip;
            dma_req <= next_dma_req;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Checks on the storage behaviour
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic f0_req, ack0_wr;
    assign ack0_wr = wr && paddr == `CRF_A_F0ACK;
    assign f0_req = rx_valid && rx_req.ext_filter_config_code == `CRF_FEC_FIFO0
                    && !ack0_wr && dep[0] != 7'h00;
    sequence s_dbg(logic [1:0] c);
        rx_valid && rx_req.ext_filter_config_code == `CRF_FEC_BUF && !rx_req.err
        && rx_req.ext_filter_second_id[10:9] == c && dbg != DBG_REQ;
    endsequence
    a_mask_and: assert property (id_valid |=>
        masked_id == ($past(rx_id) & $past(extended_id_and_mask)))
        else $error("masked id is not id AND mask");
    a_fill_bound: assert property (fill[0] <= dep[0])
        else $error("fifo0 fill above depth");
    a_full_flag: assert property ($rose(fs[0].fifo_full_status) |-> irq[`CRF_IRQ_FULL0])
        else $error("full without full flag");
    a_block_drop: assert property (f0_req && fs[0].fifo_full_status
        && !cfg[0][`CRF_CFG_OM] |=> !store.valid && fs[0].fifo_message_lost
        && irq[`CRF_IRQ_LOST0] && $stable(fs[0].fifo_put_index))
        else $error("blocking full fifo did not drop");
    a_ovw_both: assert property (f0_req && !rx_req.err && fs[0].fifo_full_status
        && cfg[0][`CRF_CFG_OM] && !$changed(cfg[0]) |=> store.valid
        && fs[0].fifo_full_status && fs[0].fifo_get_index == fs[0].fifo_put_index)
        else $error("overwrite did not advance both indices");
    // Only one message per cycle, so an errored one leaves both put indices alone
    a_err_put: assert property (rx_valid && rx_req.err
        && rx_req.ext_filter_config_code inside {`CRF_FEC_FIFO0, `CRF_FEC_FIFO1}
        |=> $stable(fs[0].fifo_put_index) && $stable(fs[1].fifo_put_index))
        else $error("errored frame moved put index");
    a_buf_lock: assert property (rx_valid && rx_req.ext_filter_config_code == `CRF_FEC_BUF
        && rx_req.ext_filter_second_id[10:9] == 2'h0 && ndat[rx_req.ext_filter_second_id[5:0]]
        |=> filter_skip && !store.valid)
        else $error("locked buffer was matched");
    a_dma_order: assert property (s_dbg(`CRF_DBG_A) ##1 !rx_valid ##1
        s_dbg(`CRF_DBG_B) ##1 !rx_valid ##1 s_dbg(`CRF_DBG_C) |=> dma_req)
        else $error("ordered debug set gave no request");
    a_dma_hold: assert property (dma_req && !dma_ack |=> dma_req ##0 !store.valid
        || store.kind != 2'h3)
        else $error("dma request dropped early");
    a_dma_ack: assert property (dma_req && dma_ack |=> !dma_req [*2])
        else $error("dma request kept after acknowledge");
endmodule : crf_rx_store
